// [irq_ctrl_cfg.svh]
`ifndef IRQ_CTRL_CFG_SVH
`define IRQ_CTRL_CFG_SVH

// Register byte addresses
`define ADDR_PEND_STATUS 32'hFFFF_C000
`define ADDR_MASK_THRESH 32'hFFFF_C004
`define ADDR_LEVEL_GRP0  32'hFFFF_C010
`define ADDR_LEVEL_GRP1  32'hFFFF_C014
`define ADDR_LEVEL_GRP2  32'hFFFF_C018
`define ADDR_LEVEL_GRP3  32'hFFFF_C01C
`define ADDR_EXT_CONFIG  32'hFFFF_C020
`define ADDR_EDGE_CLEAR  32'hFFFF_C024
`define ADDR_EVT_STATUS  32'hFFFF_C028
`define ADDR_EVT_MASK    32'hFFFF_C02C

// Field layout
`define LEVEL_W          3
`define LEVEL_STRIDE     8
`define MASK_LSB         0
`define WDT_RST_EN_BIT   16
`define NUM_SRC          16
`define NUM_PINS         8
`define NUM_EVT          3
`define EVT_REPORT       0
`define EVT_BYPASS       1
`define EVT_NMI          2

// Source numbers of the peripheral groups
`define SRC_DMA_LSB      7
`define SRC_SERIAL_LSB   11
`define SRC_TIMER_LSB    13

// Reset values
`define LEVEL_RST        3'h0
`define MASK_RST         3'h0
`define MODE_RST         16'h0000
`define EVT_MASK_RST     3'h0

`endif

// [irq_ctrl_pkg.sv]
package irq_ctrl_pkg;

  // Register bus request from software
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  // Detection mode of one external pin
  typedef enum logic [1:0] {
    DETECT_HIGH    = 2'b00,
    DETECT_LOW     = 2'b01,
    DETECT_RISING  = 2'b10,
    DETECT_FALLING = 2'b11
  } detect_mode_t;

  // Requests of the internal peripherals
  typedef struct packed {
    logic [2:0] timer;
    logic [1:0] serial;
    logic [3:0] dma;
  } periph_req_t;

endpackage : irq_ctrl_pkg

// [prioritized_interrupt_controller.sv]
`timescale 1ns/1ps
`include "irq_ctrl_cfg.svh"
// How it works
// - Arbitrated source reported: bit 4 of cause set, number on bits 3:0.
// - Lowest external pin bypasses arbitration and masking, reported on cause bit 5.
// - Pins 1-7 are sources 0-6, DMA 7-10, serial 11-12, timers 13-15.
// - Three-bit level per source; larger wins; zero is never chosen, though a held source stays reported.
// - Sources with level at or below mask threshold are not chosen; a held source stays until its request clears.
// - Equal top levels: larger source number wins.
// - Reported number held until its request clears, then re-arbitrated.
// - Status register: one bit per source, 0 pending, 1 idle.
// - Each external pin detects rising, falling, high or low per mode field.
// - Edge requests stay pending until cleared through the edge-clear field.
// - Each falling edge on the non-maskable pin requests a non-maskable interrupt.
// - Non-maskable interrupt from pin, watchdog, or core write bus error.
// - Watchdog reset enable set: watchdog timeout resets chip instead.
// - Status at C000, mask at C004, level groups at C010 to C01C.
// - Level fields at bits 2:0, 10:8, 18:16, 26:24, lowest source first.
// - Mask threshold in bits 2:0 of the mask register.
module prioritized_interrupt_controller
  import irq_ctrl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire reg_req_t    bus,
  output logic [31:0]      rdata,
  input  wire logic [7:0]  ext_int_pin,
  input  wire logic        nmi_pin_b,
  input  wire periph_req_t periph_req,
  input  wire logic        watchdog_req,
  input  wire logic        write_bus_err,
  output logic [5:0]       cause_pending_field,
  output logic             nmi_req,
  output logic             chip_reset_req,
  output logic             irq
);

  // Bit offset of a source's level field inside its group register
  function automatic logic [4:0] level_pos(input logic [3:0] src);
    level_pos = 5'(src[1:0] * `LEVEL_STRIDE);
  endfunction : level_pos

  // Address match helper
  function automatic logic hit(input logic [31:0] a, input logic [31:0] b);
    hit = (a == b);
  endfunction : hit

  // True for the two edge-triggered detection modes
  function automatic logic edge_mode(input detect_mode_t m);
    edge_mode = (m == DETECT_RISING) || (m == DETECT_FALLING);
  endfunction : edge_mode

  logic [2:0]  source_level_field [`NUM_SRC];
  logic [2:0]  mask_level_field;
  logic [15:0] external_detect_mode;
  logic        wdt_rst_en;
  logic [7:0]  pin_s1;
  logic [7:0]  pin_s2;
  logic [7:0]  pin_prev;
  logic [7:0]  edge_latch;
  logic [7:0]  edge_hits;
  logic [7:0]  pin_active;
  logic        nmi_s1;
  logic        nmi_s2;
  logic        nmi_prev;
  logic        held_valid;
  logic [3:0]  held_num;
  logic [2:0]  evt_status;
  logic [2:0]  evt_mask;

  // Register decode
  wire sel_status = hit(bus.addr, `ADDR_PEND_STATUS);
  wire sel_mask   = hit(bus.addr, `ADDR_MASK_THRESH);
  wire sel_cfg    = hit(bus.addr, `ADDR_EXT_CONFIG);
  wire sel_eclr   = hit(bus.addr, `ADDR_EDGE_CLEAR);
  wire sel_evt    = hit(bus.addr, `ADDR_EVT_STATUS);
  wire sel_emask  = hit(bus.addr, `ADDR_EVT_MASK);
  wire [3:0] sel_grp = {hit(bus.addr, `ADDR_LEVEL_GRP3),
                        hit(bus.addr, `ADDR_LEVEL_GRP2),
                        hit(bus.addr, `ADDR_LEVEL_GRP1),
                        hit(bus.addr, `ADDR_LEVEL_GRP0)};
  wire wr_eclr    = bus.wr & sel_eclr;

  // First synchroniser stage of the external pins; only stage two reads it
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pin_s1 <= 8'h00;
    end else begin
      pin_s1 <= ext_int_pin;
    end
  end

  // Second stage and edge history of the external pins
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pin_s2   <= 8'h00;
      pin_prev <= 8'h00;
    end else begin
      pin_s2   <= pin_s1;
      pin_prev <= pin_s2;
    end
  end

  // Non-maskable pin chain resets high, so leaving reset is no falling edge
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      nmi_s1 <= 1'b1;
    end else begin
      nmi_s1 <= nmi_pin_b;
    end
  end

  // Second stage and history of the non-maskable pin
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      nmi_s2   <= 1'b1;
      nmi_prev <= 1'b1;
    end else begin
      nmi_s2   <= nmi_s1;
      nmi_prev <= nmi_s2;
    end
  end

  // Per-pin detection in the selected mode
  genvar p;
  generate
    for (p = 0; p < `NUM_PINS; p++) begin : g_pin
      detect_mode_t mode;
      logic         rise;
      logic         fall;
      logic         edge_hit;
      assign mode     = detect_mode_t'(external_detect_mode[2*p +: 2]);
      assign rise     = pin_s2[p] & ~pin_prev[p];
      assign fall     = ~pin_s2[p] & pin_prev[p];
      assign edge_hit = (mode == DETECT_RISING)  ? rise :
                        (mode == DETECT_FALLING) ? fall : 1'b0;
      assign edge_hits[p] = edge_hit;
      // Level modes follow the pin; the outside party releases it
      assign pin_active[p] = edge_mode(mode) ? edge_latch[p] :
                             (mode == DETECT_HIGH) ? pin_s2[p] : ~pin_s2[p];
    end
  endgenerate

  // Edge latches; a new edge beats a clear written in the same cycle
  // Software must clear an edge request, or it stays pending forever
  wire [7:0] edge_clr        = wr_eclr ? bus.wdata[7:0] : 8'h00;
  wire [7:0] next_edge_latch = edge_hits | (edge_latch & ~edge_clr);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      edge_latch <= 8'h00;
    end else begin
      edge_latch <= next_edge_latch;
    end
  end

  // Pending vector in source-number order
  wire [15:0] pend = {periph_req.timer,
                      periph_req.serial,
                      periph_req.dma,
                      pin_active[7:1]};

  // Eligibility: nonzero level above the mask threshold
  logic [15:0] eligible;
  genvar s;
  generate
    for (s = 0; s < `NUM_SRC; s++) begin : g_elig
      assign eligible[s] = pend[s]
                         & (source_level_field[s] != 3'h0)
                         & (source_level_field[s] > mask_level_field);
    end
  endgenerate

  // Winner search; >= lets the larger number win a tie
  logic [3:0] win_num;
  logic [2:0] win_lvl;
  logic       win_any;
  always_comb begin
    win_num = 4'h0;
    win_lvl = 3'h0;
    win_any = 1'b0;
    for (int k = 0; k < `NUM_SRC; k++) begin
      if (eligible[k] && (!win_any || source_level_field[k] >= win_lvl)) begin
        win_num = 4'(k);
        win_lvl = source_level_field[k];
        win_any = 1'b1;
      end
    end
  end

  // Hold the reported source until its request goes away
  wire       keep       = held_valid & pend[held_num];
  wire       next_valid = keep | win_any;
  wire [3:0] next_num   = keep ? held_num : win_num;
  wire       new_report = next_valid & (~held_valid | (next_num != held_num));

  // Whether a source is being reported at all
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      held_valid <= 1'b0;
    end else begin
      held_valid <= next_valid;
    end
  end

  // Number of the reported source; a later higher level cannot displace it
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      held_num <= 4'h0;
    end else begin
      held_num <= next_num;
    end
  end

  // Bypass pin skips arbitration and masking; software orders it against the rest
  wire [5:0] next_cause = {pin_active[0], next_valid, next_num};

  // Cause field to the core
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cause_pending_field <= 6'h00;
    end else begin
      cause_pending_field <= next_cause;
    end
  end

  // Non-maskable causes and watchdog reset
  wire nmi_fall  = ~nmi_s2 & nmi_prev;
  wire wdt_nmi   = watchdog_req & ~wdt_rst_en;
  wire next_nmi  = nmi_fall | wdt_nmi | write_bus_err;

  wire next_chip_reset = watchdog_req & wdt_rst_en;

  // One-cycle non-maskable request per cause cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      nmi_req <= 1'b0;
    end else begin
      nmi_req <= next_nmi;
    end
  end

  // Watchdog timeout resets the chip instead when enabled
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      chip_reset_req <= 1'b0;
    end else begin
      chip_reset_req <= next_chip_reset;
    end
  end

  // Mask threshold; a source at or below it is never chosen, but one already held stays reported
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mask_level_field <= `MASK_RST;
    end else if (bus.wr && sel_mask) begin
      mask_level_field <= bus.wdata[`MASK_LSB +: `LEVEL_W];
    end
  end

  // Pin detection modes and watchdog reset enable
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      external_detect_mode <= `MODE_RST;
      wdt_rst_en           <= 1'b0;
    end else if (bus.wr && sel_cfg) begin
      external_detect_mode <= bus.wdata[15:0];
      wdt_rst_en           <= bus.wdata[`WDT_RST_EN_BIT];
    end
  end

  // Event mask, same layout as the event flags
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      evt_mask <= `EVT_MASK_RST;
    end else if (bus.wr && sel_emask) begin
      evt_mask <= bus.wdata[`NUM_EVT-1:0];
    end
  end

  // Level fields, four to a group register
  generate
    for (s = 0; s < `NUM_SRC; s++) begin : g_lvl
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          source_level_field[s] <= `LEVEL_RST;
        end else if (bus.wr && sel_grp[s/4]) begin
          source_level_field[s] <= bus.wdata[level_pos(4'(s)) +: `LEVEL_W];
        end
      end
    end
  endgenerate

  // Event flags; a new event beats the clearing read
  wire [2:0] evt_set = {next_nmi,
                        pin_active[0] & ~cause_pending_field[5],
                        new_report};
  wire       rd_evt  = bus.rd & sel_evt;

  wire [2:0] next_evt_status = evt_set | (rd_evt ? 3'h0 : evt_status);
  wire       next_irq        = |(next_evt_status & evt_mask);

  // Sticky flags, cleared by reading them
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      evt_status <= 3'h0;
    end else begin
      evt_status <= next_evt_status;
    end
  end

  // Level interrupt follows the flags that are not masked
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  // Read data selection
  logic [31:0] grp_word [4];
  generate
    for (s = 0; s < 4; s++) begin : g_grp
      assign grp_word[s] = {5'h00, source_level_field[4*s+3],
                            5'h00, source_level_field[4*s+2],
                            5'h00, source_level_field[4*s+1],
                            5'h00, source_level_field[4*s]};
    end
  endgenerate

  wire [31:0] next_rdata =
      sel_status   ? {16'h0000, ~pend} :
      sel_mask     ? {29'h0000_0000, mask_level_field} :
      sel_grp[0]   ? grp_word[0] :
      sel_grp[1]   ? grp_word[1] :
      sel_grp[2]   ? grp_word[2] :
      sel_grp[3]   ? grp_word[3] :
      sel_cfg      ? {15'h0000, wdt_rst_en, external_detect_mode} :
      sel_eclr     ? {24'h0000_00, edge_latch} :
      sel_evt      ? {29'h0000_0000, evt_status} :
      sel_emask    ? {29'h0000_0000, evt_mask} :
      32'h0000_0000;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= bus.rd ? next_rdata : 32'h0000_0000;
    end
  end

endmodule : prioritized_interrupt_controller

// [irq_ctrl_chk.sv]
`timescale 1ns/1ps
`include "irq_ctrl_cfg.svh"
module irq_ctrl_chk
  import irq_ctrl_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_b,
  input wire reg_req_t    bus,
  input wire logic [31:0] rdata,
  input wire logic [7:0]  ext_int_pin,
  input wire logic        nmi_pin_b,
  input wire periph_req_t periph_req,
  input wire logic        watchdog_req,
  input wire logic        write_bus_err,
  input wire logic [5:0]  cause_pending_field,
  input wire logic        nmi_req,
  input wire logic        chip_reset_req,
  input wire logic        irq
);
  wire logic [15:0] src_req = {periph_req.timer, periph_req.serial, periph_req.dma, 7'h00};
  wire logic [3:0]  num     = cause_pending_field[3:0];
  logic [15:0]      req_d1;
  logic [15:0]      req_d2;

  // Recent history of internal requests
  always_ff @(posedge clk) begin
    req_d1 <= src_req;
    req_d2 <= req_d1;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_read_idle: assert property (!bus.rd |=> rdata == 32'h0000_0000)
    else $error("read data not zero after idle cycle");
  chk_status_upper: assert property (bus.rd && bus.addr == `ADDR_PEND_STATUS
    |=> rdata[31:16] == 16'h0000) else $error("status upper half not zero");
  chk_level_fields: assert property (bus.rd && (bus.addr & 32'hFFFF_FFF0) == `ADDR_LEVEL_GRP0
    |=> (rdata & 32'hF8F8_F8F8) == 32'h0000_0000) else $error("level bits out of fields");
  chk_mask_field: assert property (bus.rd && bus.addr == `ADDR_MASK_THRESH
    |=> rdata[31:3] == 29'h0) else $error("mask bits out of field");
  chk_buserr_nmi: assert property (write_bus_err |=> nmi_req)
    else $error("bus error did not raise nmi");
  chk_wdog_reset: assert property (chip_reset_req |-> $past(watchdog_req))
    else $error("chip reset without watchdog");
  chk_nmi_cause: assert property (nmi_req |-> $past(write_bus_err) || $past(watchdog_req)
    || (!$past(nmi_pin_b, 3) && $past(nmi_pin_b, 4)) || (!$past(nmi_pin_b, 2) && $past(nmi_pin_b, 3)))
    else $error("nmi without cause");
  chk_cause_hold: assert property (cause_pending_field[4] && num >= 4'h7 && src_req[num]
    |=> $stable(cause_pending_field[4:0])) else $error("held source number changed");
  chk_cause_source: assert property (cause_pending_field[4] && num >= 4'h7
    |-> req_d1[num] || req_d2[num]) else $error("reported source has no request");
endmodule : irq_ctrl_chk

bind prioritized_interrupt_controller irq_ctrl_chk irq_ctrl_chk_inst (.clk(clk), .rst_b(rst_b),
  .bus(bus), .rdata(rdata), .ext_int_pin(ext_int_pin), .nmi_pin_b(nmi_pin_b),
  .periph_req(periph_req), .watchdog_req(watchdog_req), .write_bus_err(write_bus_err),
  .cause_pending_field(cause_pending_field), .nmi_req(nmi_req),
  .chip_reset_req(chip_reset_req), .irq(irq));

// [core_model.sv]
`timescale 1ns/1ps
module core_model (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [5:0] cause_pending_field,
  input  wire logic       nmi_req,
  input  wire logic       chip_reset_req,
  output logic [5:0]      cause_reg,
  output int              nmi_count,
  output int              reset_count
);
  // Core copy of the cause field and counts of one-cycle requests
  always @(posedge clk) begin
    cause_reg <= cause_pending_field;
    if (!rst_b) begin
      nmi_count <= 0;
      reset_count <= 0;
    end else begin
      nmi_count <= nmi_count + int'(nmi_req);
      reset_count <= reset_count + int'(chip_reset_req);
    end
  end
endmodule : core_model

// [prioritized_interrupt_controller_tb.sv]
`timescale 1ns/1ps
`include "irq_ctrl_cfg.svh"
module prioritized_interrupt_controller_tb
  import irq_ctrl_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  reg_req_t    bus = '0;
  logic [7:0]  ext_int_pin = 8'h14;
  logic        nmi_pin_b = 1'b1;
  periph_req_t periph_req = '0;
  logic        watchdog_req = 1'b0;
  logic        write_bus_err = 1'b0;
  logic [31:0] rdata, v;
  logic [5:0]  cause_pending_field, cause_reg;
  logic        nmi_req, chip_reset_req, irq;
  logic [8:0]  p;
  int          nmi_count, reset_count, fails = 0, checks = 0, cycles = 0, w, mask, lvl[16];
  integer      seed = 32'hd66b;
  logic [31:0] regs[6] = '{`ADDR_MASK_THRESH, `ADDR_LEVEL_GRP0, `ADDR_LEVEL_GRP1,
                           `ADDR_LEVEL_GRP2, `ADDR_LEVEL_GRP3, 32'hFFFF_C008};

  prioritized_interrupt_controller prioritized_interrupt_controller_inst (.clk(clk),
    .rst_b(rst_b), .bus(bus), .rdata(rdata), .ext_int_pin(ext_int_pin), .nmi_pin_b(nmi_pin_b),
    .periph_req(periph_req), .watchdog_req(watchdog_req), .write_bus_err(write_bus_err),
    .cause_pending_field(cause_pending_field), .nmi_req(nmi_req),
    .chip_reset_req(chip_reset_req), .irq(irq));
  core_model core_model_inst (.clk(clk), .rst_b(rst_b), .cause_pending_field(cause_pending_field),
    .nmi_req(nmi_req), .chip_reset_req(chip_reset_req), .cause_reg(cause_reg),
    .nmi_count(nmi_count), .reset_count(reset_count));

  // Clock and hang limit
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      complete_run();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [31:0] a, d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask : wr

  // Read data are taken in the cycle after the strobe
  task automatic rd(input logic [31:0] a);
    @(posedge clk);
    bus <= '{a, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 v = rdata;
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  // Reference arbiter: larger level wins, ties to the larger number
  function automatic int winner(input logic [15:0] r);
    winner = -1;
    for (int s = 0; s < 16; s++)
      if (r[s] && lvl[s] > mask && (winner < 0 || lvl[s] >= lvl[winner])) winner = s;
  endfunction : winner

  task automatic cause_is(input int src);
    check("cause", 32'(cause_pending_field[4:0] & (src < 0 ? 5'h10 : 5'h1f)),
          src < 0 ? 0 : 16 + src);
  endtask : cause_is

  task automatic set_req(input logic [8:0] r);
    @(posedge clk);
    periph_req <= r;
    settle(3);
  endtask : set_req

  task automatic complete_run();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    foreach (regs[i]) begin
      rd(regs[i]);
      check("reset", v, 32'h0000_0000);
    end
    wr(`ADDR_EXT_CONFIG, 32'h0000_0138);
    for (int g = 0; g < 4; g++) begin
      v = $random(seed) & 32'h0707_0707;
      for (int k = 0; k < 4; k++) lvl[4 * g + k] = int'(v[8 * k +: 3]);
      wr(`ADDR_LEVEL_GRP0 + 4 * g, v);
      rd(`ADDR_LEVEL_GRP0 + 4 * g);
      check("level", v, {5'h0, 3'(lvl[4*g+3]), 5'h0, 3'(lvl[4*g+2]), 5'h0, 3'(lvl[4*g+1]),
            5'h0, 3'(lvl[4*g])});
    end
    mask = $random(seed) & 7;
    wr(`ADDR_MASK_THRESH, 32'(mask));
    rd(`ADDR_MASK_THRESH);
    check("mask", v, 32'(mask));
    repeat (20) begin
      v = $random(seed);
      p = v[8:0];
      set_req(p);
      cause_is(winner({p, 7'h00}));
      rd(`ADDR_PEND_STATUS);
      check("status", {16'h0000, v[15:0]}, {16'h0000, ~{p, 7'h00}});
      set_req(9'h000);
      cause_is(-1);
    end
    wr(`ADDR_LEVEL_GRP3, 32'h0700_0000);
    wr(`ADDR_MASK_THRESH, 32'h0000_0000);
    set_req(9'h040);
    cause_is(-1);
    wr(`ADDR_LEVEL_GRP3, 32'h0700_0200);
    settle(2);
    cause_is(13);
    set_req(9'h140);
    cause_is(13);
    set_req(9'h100);
    cause_is(15);
    set_req(9'h000);
    wr(`ADDR_MASK_THRESH, 32'h0000_0002);
    set_req(9'h040);
    cause_is(-1);
    set_req(9'h000);
    for (int k = 1; k < 5; k++) begin
      @(posedge clk);
      ext_int_pin <= 8'h14 ^ (8'h01 << k);
      settle(5);
      rd(`ADDR_PEND_STATUS);
      check("pin active", 32'(v[k-1]), 32'h0000_0000);
      @(posedge clk);
      ext_int_pin <= 8'h14;
      settle(5);
      rd(`ADDR_PEND_STATUS);
      check("pin idle", 32'(v[k-1]), 32'(k > 2));
      wr(`ADDR_EDGE_CLEAR, 32'h0000_0001 << k);
      rd(`ADDR_PEND_STATUS);
      check("pin cleared", 32'(v[k-1]), 32'h0000_0001);
    end
    @(posedge clk);
    ext_int_pin <= 8'h15;
    settle(5);
    check("bypass", 32'(cause_reg[5]), 32'h0000_0001);
    @(posedge clk);
    ext_int_pin <= 8'h14;
    nmi_pin_b <= 1'b0;
    settle(5);
    check("bypass off", 32'(cause_reg[5]), 32'h0000_0000);
    rd(`ADDR_EVT_STATUS);
    @(posedge clk);
    nmi_pin_b <= 1'b1;
    write_bus_err <= 1'b1;
    @(posedge clk);
    write_bus_err <= 1'b0;
    watchdog_req <= 1'b1;
    @(posedge clk);
    watchdog_req <= 1'b0;
    settle(3);
    check("nmi count", nmi_count, 3);
    check("irq masked", 32'(irq), 32'h0000_0000);
    wr(`ADDR_EXT_CONFIG, 32'h0001_0138);
    @(posedge clk);
    watchdog_req <= 1'b1;
    @(posedge clk);
    watchdog_req <= 1'b0;
    settle(3);
    check("reset count", reset_count, 1);
    check("nmi held", nmi_count, 3);
    wr(`ADDR_EVT_MASK, 32'h0000_0004);
    settle(2);
    check("irq set", 32'(irq), 32'h0000_0001);
    rd(`ADDR_EVT_STATUS);
    check("event", 32'(v[2]), 32'h0000_0001);
    settle(2);
    check("irq clear", 32'(irq), 32'h0000_0000);
    complete_run();
  end
endmodule : prioritized_interrupt_controller_tb
